/* design/ccr_map.vh */
`ifndef CCR_MAP_VH
`define CCR_MAP_VH

// Register word indices; byte address is index times four
`define CCR_IDX_MODE     5'h00
`define CCR_IDX_CMD      5'h01
`define CCR_IDX_STATUS   5'h02
`define CCR_IDX_IRQEN    5'h03
`define CCR_IDX_BTPRE    5'h04
`define CCR_IDX_BTSEG    5'h05
`define CCR_IDX_OUTCTL   5'h06
`define CCR_IDX_ARBCAP   5'h07
`define CCR_IDX_ERRCAP   5'h08
`define CCR_IDX_EWLIM    5'h09
`define CCR_IDX_RECEIVE_ERROR_COUNTER    5'h0a
`define CCR_IDX_TRANSMIT_ERROR_COUNTER    5'h0b
`define CCR_IDX_RXBUF    5'h0c
`define CCR_IDX_ACODE    5'h0d
`define CCR_IDX_AMASK    5'h0e
`define CCR_IDX_MSGCNT   5'h0f
`define CCR_IDX_RXSTART  5'h10
`define CCR_IDX_CLKDIV   5'h11
`define CCR_IDX_LAST     5'h11

// Field positions
`define CCR_MODE_RESET_BIT   0
`define CCR_CMD_RELEASE_BIT  0
`define CCR_STAT_RESET_BIT   0
`define CCR_STAT_BUSOFF_BIT  1
`define CCR_STAT_WARN_BIT    2

// Reset and preset values
`define CCR_RST_MODE         1'b1
`define CCR_RST_ZERO8        8'h00
`define CCR_RST_EWLIM        8'h60
`define CCR_BUSOFF_TRANSMIT_ERROR_COUNTER     8'h7f
`define CCR_RST_CLKDIV_A     8'h00
`define CCR_RST_CLKDIV_B     8'h05
`define CCR_CNT_MAX          8'hff

// Receive FIFO address width (64 bytes)
`define CCR_FIFO_AW          6

// Edges after reset release before the strap is trusted
`define CCR_STRAP_WAIT       2'h2

// AHB encodings
`define CCR_HRESP_OKAY       1'b0

`endif

/* design/ccr_regs.v */
// The AHB-Lite register port and the placing of the registers are this design's own decisions.
`include "ccr_map.vh"
`default_nettype none

module ccr_regs #(
  parameter AW = `CCR_FIFO_AW
) (
  input  wire        mclk,
  input  wire        resetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire        hready,
  input  wire [31:0] hwdata,
  input  wire        busStylePin,
  input  wire        arbLostValid,
  input  wire [7:0]  arbLostBit,
  input  wire        busErrValid,
  input  wire [7:0]  busErrCode,
  input  wire        rxErrStep,
  input  wire        txErrStep,
  input  wire        busOffEvent,
  input  wire        recessiveSeq,
  input  wire        rxByteValid,
  input  wire [7:0]  rxByte,
  input  wire        rxMsgDone,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  output reg         resetModeOut,
  output reg         busOffOut,
  output reg         errWarnOut,
  output reg         frameAbort
);

  // Bus pipeline state
  reg          wrPend_r;
  reg          rdPend_r;
  reg  [4:0]   idx_r;
  reg          hit_r;

  // Registers cleared or loaded by hardware reset
  reg  [7:0]   arbCap_r;
  reg  [7:0]   errCap_r;
  reg  [7:0]   ewLim_r;
  reg  [7:0]   receive_error_counter_r;
  reg  [7:0]   transmit_error_counter_r;
  reg  [7:0]   msgCnt_r;
  reg  [7:0]   rxStart_r;
  reg  [7:0]   clkDiv_r;
  reg  [AW-1:0] rdPtr_r;
  reg  [AW-1:0] wrPtr_r;
  reg  [1:0]   startCnt_r;
  reg          divLoaded_r;

  // Registers that no reset touches
  reg  [7:0]   irqEn_r;
  reg  [7:0]   btPre_r;
  reg  [7:0]   btSeg_r;
  reg  [7:0]   outCtl_r;
  reg  [31:0]  aCode_r;
  reg  [31:0]  aMask_r;
  reg  [7:0]   fifo [0:(1<<AW)-1];

  wire         styleSync;
  wire         addrPhase;
  wire         addrOk;
  wire         wrStb;
  wire         rmWrStb;
  wire         modeNxt;
  wire         enterRm;
  wire         relCmd;
  wire         popRx;
  wire         recovering;
  reg  [31:0]  rdMux;

  // Strap pin crosses two flops before anyone reads it
  ccr_sync #(
    .W (1)
  ) uStrap (
    .mclk   (mclk),
    .resetn (resetn),
    .din    (busStylePin),
    .dout   (styleSync)
  );

  // Address phase decode; words above index 0x11 (CLKDIV) are unmapped
  assign addrPhase = hsel & htrans[1] & hready;
  assign addrOk    = (haddr[31:7] == 25'h0) & (haddr[1:0] == 2'h0) &
                     (haddr[6:2] <= `CCR_IDX_LAST);
  assign wrStb     = wrPend_r & hit_r;
  // Configuration writes other than IRQEN and CLKDIV are only taken while in reset mode
  assign rmWrStb   = wrStb & resetModeOut;

  // Bus-off forces reset mode; software sets or clears it
  assign modeNxt = busOffEvent ? 1'b1 :
                   (wrStb & (idx_r == `CCR_IDX_MODE)) ?
                   hwdata[`CCR_MODE_RESET_BIT] : resetModeOut;
  assign enterRm = modeNxt & ~resetModeOut;
  assign relCmd  = wrStb & (idx_r == `CCR_IDX_CMD) &
                   hwdata[`CCR_CMD_RELEASE_BIT];
  assign popRx   = rdPend_r & hit_r & (idx_r == `CCR_IDX_RXBUF);
  // Recovery sequences count only once software leaves reset mode
  assign recovering = busOffOut & ~resetModeOut & recessiveSeq;

  // AHB-Lite slave: writes zero wait, reads one wait state
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wrPend_r  <= 1'b0;
      rdPend_r  <= 1'b0;
      idx_r     <= 5'h00;
      hit_r     <= 1'b0;
      hreadyout <= 1'b1;
      hresp     <= `CCR_HRESP_OKAY;
      hrdata    <= 32'h0000_0000;
    end else begin
      hresp <= `CCR_HRESP_OKAY;
      if (rdPend_r) begin
        // Read data sampled after any preceding write has landed
        hrdata    <= rdMux;
        hreadyout <= 1'b1;
        rdPend_r  <= 1'b0;
        wrPend_r  <= 1'b0;
      end else begin
        wrPend_r <= addrPhase & hwrite;
        rdPend_r <= addrPhase & ~hwrite;
        if (addrPhase) begin
          idx_r     <= haddr[6:2];
          hit_r     <= addrOk;
          hreadyout <= hwrite;
        end
      end
    end
  end

  // Read multiplexer; unmapped and write-only words read as zero
  always @* begin
    rdMux = 32'h0000_0000;
    if (hit_r) begin
      case (idx_r)
        `CCR_IDX_MODE:    rdMux[`CCR_MODE_RESET_BIT] = resetModeOut;
        `CCR_IDX_STATUS: begin
          rdMux[`CCR_STAT_RESET_BIT]  = resetModeOut;
          rdMux[`CCR_STAT_BUSOFF_BIT] = busOffOut;
          rdMux[`CCR_STAT_WARN_BIT]   = errWarnOut;
        end
        `CCR_IDX_IRQEN:   rdMux[7:0] = irqEn_r;
        `CCR_IDX_BTPRE:   rdMux[7:0] = btPre_r;
        `CCR_IDX_BTSEG:   rdMux[7:0] = btSeg_r;
        `CCR_IDX_OUTCTL:  rdMux[7:0] = outCtl_r;
        `CCR_IDX_ARBCAP:  rdMux[7:0] = arbCap_r;
        `CCR_IDX_ERRCAP:  rdMux[7:0] = errCap_r;
        `CCR_IDX_EWLIM:   rdMux[7:0] = ewLim_r;
        `CCR_IDX_RECEIVE_ERROR_COUNTER:   rdMux[7:0] = receive_error_counter_r;
        `CCR_IDX_TRANSMIT_ERROR_COUNTER:   rdMux[7:0] = transmit_error_counter_r;
        // Stale bytes may show here after a reset, by design
        `CCR_IDX_RXBUF:   rdMux[7:0] = fifo[rdPtr_r];
        `CCR_IDX_ACODE:   rdMux      = aCode_r;
        `CCR_IDX_AMASK:   rdMux      = aMask_r;
        `CCR_IDX_MSGCNT:  rdMux[7:0] = msgCnt_r;
        `CCR_IDX_RXSTART: rdMux[7:0] = rxStart_r;
        `CCR_IDX_CLKDIV:  rdMux[7:0] = clkDiv_r;
        default:          rdMux      = 32'h0000_0000;
      endcase
    end
  end

  // Mode bit, bus-off state, abort pulse and warning level
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      resetModeOut <= `CCR_RST_MODE;
      busOffOut    <= 1'b0;
      frameAbort   <= 1'b0;
      errWarnOut   <= 1'b0;
    end else begin
      resetModeOut <= modeNxt;
      frameAbort   <= enterRm;
      errWarnOut   <= (receive_error_counter_r >= ewLim_r) | (transmit_error_counter_r >= ewLim_r);
      if (busOffEvent) begin
        busOffOut <= 1'b1;
      end else if (recovering && transmit_error_counter_r == `CCR_RST_ZERO8) begin
        busOffOut <= 1'b0;
      end
    end
  end

  // Error counters; bus-off entry presets them, software entry keeps them
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      receive_error_counter_r <= `CCR_RST_ZERO8;
      transmit_error_counter_r <= `CCR_RST_ZERO8;
    end else if (busOffEvent) begin
      receive_error_counter_r <= `CCR_RST_ZERO8;
      transmit_error_counter_r <= `CCR_BUSOFF_TRANSMIT_ERROR_COUNTER;
    end else if (recovering) begin
      // 127 down to 0 then one more sequence: 128 in all
      if (transmit_error_counter_r != `CCR_RST_ZERO8) begin
        transmit_error_counter_r <= transmit_error_counter_r - 8'h01;
      end
    end else if (resetModeOut) begin
      // Software entry alone leaves both counters as they were
      if (rmWrStb && idx_r == `CCR_IDX_RECEIVE_ERROR_COUNTER) begin
        receive_error_counter_r <= hwdata[7:0];
      end
      if (rmWrStb && idx_r == `CCR_IDX_TRANSMIT_ERROR_COUNTER) begin
        transmit_error_counter_r <= hwdata[7:0];
      end
    end else begin
      // Saturate rather than wrap; wrap would fake a healthy node
      if (rxErrStep && receive_error_counter_r != `CCR_CNT_MAX) begin
        receive_error_counter_r <= receive_error_counter_r + 8'h01;
      end
      if (txErrStep && transmit_error_counter_r != `CCR_CNT_MAX) begin
        transmit_error_counter_r <= transmit_error_counter_r + 8'h01;
      end
    end
  end

  // Capture registers: only hardware reset clears them
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      arbCap_r <= `CCR_RST_ZERO8;
      errCap_r <= `CCR_RST_ZERO8;
    end else begin
      if (arbLostValid && !resetModeOut) begin
        arbCap_r <= arbLostBit;
      end
      if (busErrValid && !resetModeOut) begin
        errCap_r <= busErrCode;
      end
    end
  end

  // Warning limit and FIFO start: preset by hardware reset only
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ewLim_r   <= `CCR_RST_EWLIM;
      rxStart_r <= `CCR_RST_ZERO8;
    end else begin
      if (rmWrStb && idx_r == `CCR_IDX_EWLIM) begin
        ewLim_r <= hwdata[7:0];
      end
      if (relCmd && !resetModeOut) begin
        // Releasing a message moves the start to the next one
        rxStart_r <= {{(8-AW){1'b0}}, rdPtr_r};
      end else if (rmWrStb && idx_r == `CCR_IDX_RXSTART) begin
        rxStart_r <= hwdata[7:0];
      end
    end
  end

  // Message counter: cleared on either reset source
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      msgCnt_r <= `CCR_RST_ZERO8;
    end else if (enterRm) begin
      msgCnt_r <= `CCR_RST_ZERO8;
    end else if (!resetModeOut) begin
      // A store and a release in one cycle cancel out unless the count is zero, when the store still counts
      if (rxMsgDone && !(relCmd && msgCnt_r != `CCR_RST_ZERO8)) begin
        if (msgCnt_r != `CCR_CNT_MAX) begin
          msgCnt_r <= msgCnt_r + 8'h01;
        end
      end else if (!rxMsgDone && relCmd &&
                   msgCnt_r != `CCR_RST_ZERO8) begin
        msgCnt_r <= msgCnt_r - 8'h01;
      end
    end
  end

  // FIFO pointers: RAM zero on hardware reset, start address on entry
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rdPtr_r <= {AW{1'b0}};
      wrPtr_r <= {AW{1'b0}};
    end else if (enterRm) begin
      rdPtr_r <= rxStart_r[AW-1:0];
      wrPtr_r <= rxStart_r[AW-1:0];
    end else if (!resetModeOut) begin
      if (rxByteValid) begin
        wrPtr_r <= wrPtr_r + {{(AW-1){1'b0}}, 1'b1};
      end
      if (popRx) begin
        rdPtr_r <= rdPtr_r + {{(AW-1){1'b0}}, 1'b1};
      end
    end
  end

  // FIFO storage; contents are never cleared
  always @(posedge mclk) begin
    if (rxByteValid && !resetModeOut) begin
      fifo[wrPtr_r] <= rxByte;
    end
  end

  // Clock divider: strap picks the value once the synchroniser settles
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      clkDiv_r    <= `CCR_RST_CLKDIV_A;
      startCnt_r  <= 2'h0;
      divLoaded_r <= 1'b0;
    end else begin
      if (startCnt_r != `CCR_STRAP_WAIT) begin
        startCnt_r <= startCnt_r + 2'h1;
      end
      if (!divLoaded_r && startCnt_r == `CCR_STRAP_WAIT) begin
        divLoaded_r <= 1'b1;
        clkDiv_r    <= styleSync ? `CCR_RST_CLKDIV_B :
                                   `CCR_RST_CLKDIV_A;
      end else if (wrStb && idx_r == `CCR_IDX_CLKDIV) begin
        clkDiv_r <= hwdata[7:0];
      end
    end
  end

  // Configuration without any reset, so both sources leave it alone
  always @(posedge mclk) begin
    if (wrStb && idx_r == `CCR_IDX_IRQEN) begin
      irqEn_r <= hwdata[7:0];
    end
    if (rmWrStb && idx_r == `CCR_IDX_BTPRE) begin
      btPre_r <= hwdata[7:0];
    end
    if (rmWrStb && idx_r == `CCR_IDX_BTSEG) begin
      btSeg_r <= hwdata[7:0];
    end
    if (rmWrStb && idx_r == `CCR_IDX_OUTCTL) begin
      outCtl_r <= hwdata[7:0];
    end
    if (rmWrStb && idx_r == `CCR_IDX_ACODE) begin
      aCode_r <= hwdata;
    end
    if (rmWrStb && idx_r == `CCR_IDX_AMASK) begin
      aMask_r <= hwdata;
    end
  end

endmodule // ccr_regs

`default_nettype wire

/* design/ccr_sync.v */
`default_nettype none

// Two-flop synchroniser for pin levels; only stage two is read outside
module ccr_sync #(
  parameter W = 1
) (
  input  wire         mclk,
  input  wire         resetn,
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout
);

  reg [W-1:0] meta_r;

  // Stage one feeds only stage two
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      meta_r <= {W{1'b0}};
      dout   <= {W{1'b0}};
    end else begin
      meta_r <= din;
      dout   <= meta_r;
    end
  end

endmodule // ccr_sync

`default_nettype wire

/* sim/ccr_host.sv */
`default_nettype none

module ccr_host (
  input  wire logic        mclk,
  input  wire logic        hreadyout,
  output var  logic        hsel,
  output var  logic [31:0] haddr,
  output var  logic [1:0]  htrans,
  output var  logic        hwrite,
  output var  logic [2:0]  hsize,
  output var  logic [31:0] hwdata
);
  timeunit 1ns;
  timeprecision 100ps;
  bit timedOut;

  // Idle bus at time zero; word transfers only
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    timedOut = 1'b0;
  end

  // Bounded wait for hready; a hung slave is flagged, not waited on forever
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 64);
    if (hreadyout !== 1'b1) timedOut = 1'b1;
  endtask

  // One single transfer: address phase, then data phase
  task automatic xfer(input bit w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
  endtask
endmodule // ccr_host

`default_nettype wire

/* sim/ccr_regs_props.sv */
`default_nettype none

module ccr_regs_props (
  input wire logic        mclk,
  input wire logic        resetn,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        resetModeOut,
  input wire logic        busOffOut,
  input wire logic        frameAbort,
  input wire logic        busOffEvent,
  input wire logic        recessiveSeq
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  // Accepted address phases
  logic rdTake;
  logic wrPh_r;
  assign rdTake = hsel && htrans[1] && hready && !hwrite;

  // Write data phase marker, so a mode change can be traced to its write
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) wrPh_r <= 1'b0;
    else wrPh_r <= hsel && htrans[1] && hready && hwrite;
  end

  property p_okay; hresp == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("hresp not okay");
  property p_rdWait; rdTake |=> !hreadyout ##1 hreadyout; endproperty
  a_rdWait: assert property (p_rdWait) else $error("read wait wrong");
  property p_lowCause; $fell(hreadyout) |-> $past(rdTake); endproperty
  a_lowCause: assert property (p_lowCause) else $error("stray wait state");
  property p_rdHold; $changed(hrdata) |-> $past(rdTake, 2); endproperty
  a_rdHold: assert property (p_rdHold) else $error("hrdata moved");
  property p_boEnter;
    busOffEvent |=> resetModeOut && busOffOut;
  endproperty
  a_boEnter: assert property (p_boEnter)
    else $error("bus-off entry");
  // Abort pulse is registered alongside the mode bit, so both rise together
  property p_abort; $rose(resetModeOut) |-> frameAbort ##1 !frameAbort;
  endproperty
  a_abort: assert property (p_abort) else $error("abort pulse");
  property p_modeCause;
    $rose(resetModeOut) |-> $past(busOffEvent) || $past(wrPh_r);
  endproperty
  a_modeCause: assert property (p_modeCause)
    else $error("mode cause");
  property p_boClear;
    $fell(busOffOut) |-> $past(recessiveSeq) && !$past(resetModeOut);
  endproperty
  a_boClear: assert property (p_boClear)
    else $error("bus-off clear");
  property p_boHold; busOffOut && resetModeOut |=> busOffOut; endproperty
  a_boHold: assert property (p_boHold) else $error("bus-off lost");
endmodule // ccr_regs_props

bind ccr_regs ccr_regs_props u_props (.mclk, .resetn, .hsel, .htrans,
  .hwrite, .hready, .hrdata, .hreadyout, .hresp, .resetModeOut,
  .busOffOut, .frameAbort, .busOffEvent, .recessiveSeq);

`default_nettype wire

/* sim/ccr_regs_test.sv */
`default_nettype none

module ccr_regs_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic        mclk, resetn, busStylePin, busOffEvent, recessiveSeq;
  logic        arbLostValid, busErrValid, rxErrStep, txErrStep;
  logic        rxByteValid, rxMsgDone, hsel, hwrite;
  bit          rdPh;
  logic        hreadyout, hresp, resetModeOut, busOffOut;
  logic        errWarnOut, frameAbort;
  logic [7:0]  arbLostBit, busErrCode, rxByte;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata;
  logic [31:0] expQ [$];
  logic [7:0]  rxQ [$];
  logic [31:0] cfgA [6];
  logic [31:0] cfgV [6];
  logic [31:0] stA [8];
  logic [31:0] st [8];
  int          num_errors, n_compared;

  ccr_regs dut (.mclk, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hready(hreadyout), .hwdata, .busStylePin, .arbLostValid, .arbLostBit,
    .busErrValid, .busErrCode, .rxErrStep, .txErrStep, .busOffEvent,
    .recessiveSeq, .rxByteValid, .rxByte, .rxMsgDone, .hrdata, .hreadyout,
    .hresp, .resetModeOut, .busOffOut, .errWarnOut, .frameAbort);
  ccr_host host (.mclk, .hreadyout, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata);

  // 40 MHz clock
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Expected read data is noted before the transfer starts
  task automatic rd(logic [31:0] a, logic [31:0] e);
    expQ.push_back(e);
    host.xfer(1'b0, a, 32'h0);
  endtask

  // Pulses events for n cycles and tracks the expected register state
  task automatic ev(int n, logic [6:0] m);
    logic [31:0] b;
    repeat (n) begin
      @(posedge mclk);
      b = $urandom;
      {busOffEvent, recessiveSeq, arbLostValid, busErrValid} <= m[6:3];
      {rxErrStep, txErrStep, rxMsgDone, rxByteValid} <= {m[2:0], m[0]};
      {arbLostBit, busErrCode, rxByte} <= b[23:0];
      if (m[4]) st[0] = b[23:16];
      if (m[0]) rxQ.push_back(b[7:0]);
      if (m[3]) st[1] = b[15:8];
      st[3] += m[2];
      st[4] += m[1];
      st[5] += m[0];
      if (m[5] && st[4] != 0) st[4]--;
      if (m[6]) st[3:5] = '{0, 127, 0};
    end
    @(posedge mclk);
    {busOffEvent, recessiveSeq, arbLostValid, busErrValid} <= 4'h0;
    {rxErrStep, txErrStep, rxMsgDone, rxByteValid} <= 4'h0;
  endtask

  task automatic chk_st();
    for (int i = 0; i < 8; i++)
      rd(stA[i], st[i]);
  endtask

  task automatic chk_cfg();
    for (int i = 0; i < 6; i++)
      rd(cfgA[i], cfgV[i]);
  endtask

  // Read data is judged at the edge that ends the read data phase
  always @(posedge mclk) begin
    if (rdPh && hreadyout === 1'b1 && expQ.size() > 0) begin
      check($sformatf("read %h", haddr), hrdata, expQ.pop_front());
      rdPh = 1'b0;
    end
    if (hsel && htrans == 2'h2 && hreadyout === 1'b1 && !hwrite) rdPh = 1'b1;
    if (host.timedOut) begin
      num_errors++;
      tally_and_finish();
    end
  end

  initial begin
    {resetn, busStylePin, busOffEvent, recessiveSeq, rxByteValid} = 5'h0;
    {arbLostValid, busErrValid, rxErrStep, txErrStep, rxMsgDone} = 5'h0;
    {arbLostBit, busErrCode, rxByte} = 24'h0;
    {num_errors, n_compared} = 0;
    void'($urandom(10));
    stA = '{32'h1c, 32'h20, 32'h24, 32'h28, 32'h2c, 32'h3c, 32'h40, 32'h44};
    st = '{0, 0, 32'h60, 0, 0, 0, 0, 0};
    cfgA = '{32'h0c, 32'h10, 32'h14, 32'h18, 32'h34, 32'h38};
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    repeat (4) @(posedge mclk);
    chk_st();
    rd(32'h00, 32'h1);
    rd(32'h48, 32'h0);
    $display("test hardware reset values done");
    // Load configuration while in reset mode; the read-only write is dropped
    for (int i = 0; i < 6; i++) begin
      cfgV[i] = (i < 4) ? ($urandom & 32'hff) : $urandom;
      host.xfer(1'b1, cfgA[i], cfgV[i]);
    end
    st[2:7] = '{$urandom & 255, $urandom % 100, $urandom % 100, 0,
      $urandom % 16, $urandom & 255};
    for (int i = 2; i < 8; i++) if (i != 5) host.xfer(1'b1, stA[i], st[i]);
    host.xfer(1'b1, 32'h1c, 32'hff);
    host.xfer(1'b1, 32'h00, 32'h0);
    ev(3, 7'h1f);
    chk_st();
    check("errWarnOut", errWarnOut, st[3] >= st[2] || st[4] >= st[2]);
    // Pop one byte, then release: start moves to the read pointer
    rd(32'h30, rxQ[0]);
    host.xfer(1'b1, 32'h04, 32'h1);
    st[5]--;
    st[6] = 1;
    rd(32'h3c, st[5]);
    rd(32'h40, st[6]);
    host.xfer(1'b1, 32'h00, 32'h1);
    st[5] = 0;
    chk_st();
    // Software entry puts the pointers back at the start address
    rd(32'h30, rxQ[1]);
    chk_cfg();
    $display("test software reset entry done");
    host.xfer(1'b1, 32'h00, 32'h0);
    ev(1, 7'h40);
    #1 check("mode and bus-off", {resetModeOut, busOffOut}, 32'h3);
    chk_st();
    check("errWarnOut", errWarnOut, st[3] >= st[2] || st[4] >= st[2]);
    rd(32'h30, rxQ[1]);
    host.xfer(1'b1, 32'h00, 32'h0);
    ev(127, 7'h20);
    chk_st();
    check("busOffOut held", busOffOut, 32'h1);
    ev(1, 7'h20);
    #1 check("busOffOut cleared", busOffOut, 32'h0);
    chk_cfg();
    $display("test bus-off entry and recovery done");
    @(posedge mclk);
    resetn <= 1'b0;
    busStylePin <= 1'b1;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    repeat (4) @(posedge mclk);
    st = '{0, 0, 32'h60, 0, 0, 0, 0, 32'h5};
    chk_st();
    chk_cfg();
    // Hardware reset returns the pointers to RAM address zero
    rd(32'h30, rxQ[0]);
    check("errWarnOut", errWarnOut, 32'h0);
    $display("test second hardware reset done");
    // One more edge so the monitor judges the last read first
    @(posedge mclk);
    tally_and_finish();
  end
endmodule // ccr_regs_test

`default_nettype wire
